/* File: hw/sskdb_pkg.sv */
package sskdb_pkg;
    // byte offsets in the socket functions' configuration space
    localparam logic [7:0] SYSCTL_OFS = 8'h80;
    localparam logic [7:0] DEBOUNCE_OFS = 8'h84;
    localparam logic [2:0] FUNC_SOCK0 = 3'h0;
    localparam logic [2:0] FUNC_SOCK1 = 3'h1;

    // system control low bits
    localparam int WAKE_SEL_BIT = 0;
    localparam int HOLD_CLK_BIT = 1;
    localparam int VOLT_BIT = 2;
    localparam int DMA_EN_BIT = 3;
    localparam int PERR_FWD_BIT = 4;
    localparam logic SYSCTL_BIT_RST = 1'b0;

    localparam int DEBOUNCE_W = 8;
    localparam logic [7:0] DEBOUNCE_RST = 8'h19;

    // one debounce step
    localparam int STEP_US = 2000;
    localparam int CLK_MHZ = 125;
    localparam int STEP_CYCLES = STEP_US * CLK_MHZ;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] func;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } sskdb_cfg_req_t;
endpackage : sskdb_pkg

/* File: hw/sskdb_top.sv */
// Contract
// - parity forward bit, rw, reset 0; set forwards card parity errors to system error
// - centralized dma enable bit, rw, reset 0, turns centralized dma on or off
// - read-only legacy voltage bit: 0 is 3.3 V, 1 is 5 V, reset 3.3 V
// - hold-clocks bit set keeps bus and card clocks running via clkrun
// - wake/ring select set drives wake signal onto shared terminal
// - select clear and ring enable set drives ring indicate onto terminal
// - select and ring enable both clear leave shared terminal undriven
// - global system control bits are accessed through function 0 only
// - system control bits clear only on global reset, not function resets
// - debounce register counts the interval in 2 ms steps
// - debounce register resets to 19h, a 50 ms interval
// - all debounce bits are rw and reset only by global reset
// - debounce register sits at 84h in function 0 and function 1
module sskdb_top #(
    parameter int STEP_CYCLES = sskdb_pkg::STEP_CYCLES
) (
    input wire logic CLK, // 125 MHz configuration clock
    input wire logic SRST, // global reset, synchronous
    input wire logic CE, // clock enable, freezes all state when low
    input wire sskdb_pkg::sskdb_cfg_req_t CFG_REQ, // configuration access request
    output logic [31:0] CFG_RDATA, // read data, valid with CFG_ACK
    output logic CFG_ACK, // access done pulse
    input wire logic CARD_PARITY_ERR, // card data parity error pulse
    input wire logic LEGACY_5V_SEL, // legacy socket power control state
    input wire logic RING_IND_EN, // ring indicate output enable from card control
    input wire logic PME_SIG, // internal wake event level
    input wire logic RING_IND_SIG, // internal ring indicate level
    input wire logic MEDIA_CARD_DETECT_N, // media card detect pin, async
    output logic SERR_REQ, // system error request pulse
    output logic DMA_ENABLE, // centralized dma enable
    output logic HOLD_CLOCKS_RUNNING, // clkrun keep both clocks running
    output logic WAKE_RING_O, // shared wake/ring terminal level
    output logic WAKE_RING_OE, // shared wake/ring terminal drive enable
    output logic MEDIA_PRESENT // debounced media card detect
);
    localparam int PRE_W = $clog2(STEP_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

    logic perr_fwd_q;
    logic hold_clk_q;
    logic wake_sel_q;
    logic volt_q;
    logic [7:0] debounce_q;
    logic [2:0] det_sync_q;
    logic det_raw_q;
    logic [PRE_W-1:0] pre_q;
    logic [7:0] steps_q;

    function automatic logic hit(input sskdb_pkg::sskdb_cfg_req_t r, input logic [7:0] ofs);
        hit = (r.func == sskdb_pkg::FUNC_SOCK0 || r.func == sskdb_pkg::FUNC_SOCK1)
            && r.addr == ofs;
    endfunction : hit

    logic sys_wr;
    logic deb_wr;
    assign sys_wr = CFG_REQ.wr && CFG_REQ.be[0] && CFG_REQ.func == sskdb_pkg::FUNC_SOCK0
        && CFG_REQ.addr == sskdb_pkg::SYSCTL_OFS;
    assign deb_wr = CFG_REQ.wr && CFG_REQ.be[0]
        && hit(CFG_REQ, sskdb_pkg::DEBOUNCE_OFS);

    // only the global reset clears these; no function reset reaches them
    always_ff @(posedge CLK) begin
        if (SRST) begin
            perr_fwd_q <= sskdb_pkg::SYSCTL_BIT_RST;
            DMA_ENABLE <= sskdb_pkg::SYSCTL_BIT_RST;
            hold_clk_q <= sskdb_pkg::SYSCTL_BIT_RST;
            wake_sel_q <= sskdb_pkg::SYSCTL_BIT_RST;
        end else if (CE && sys_wr) begin
            perr_fwd_q <= CFG_REQ.wdata[sskdb_pkg::PERR_FWD_BIT];
            DMA_ENABLE <= CFG_REQ.wdata[sskdb_pkg::DMA_EN_BIT];
            hold_clk_q <= CFG_REQ.wdata[sskdb_pkg::HOLD_CLK_BIT];
            wake_sel_q <= CFG_REQ.wdata[sskdb_pkg::WAKE_SEL_BIT];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            volt_q <= sskdb_pkg::SYSCTL_BIT_RST;
        end else if (CE) begin
            volt_q <= LEGACY_5V_SEL;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            debounce_q <= sskdb_pkg::DEBOUNCE_RST;
        end else if (CE && deb_wr) begin
            debounce_q <= CFG_REQ.wdata[sskdb_pkg::DEBOUNCE_W-1:0];
        end
    end

    // read path; global bits read as zero from function 1
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CFG_RDATA <= 32'h0;
            CFG_ACK <= 1'b0;
        end else if (CE) begin
            CFG_ACK <= CFG_REQ.wr || CFG_REQ.rd;
            CFG_RDATA <= 32'h0;
            if (CFG_REQ.rd && hit(CFG_REQ, sskdb_pkg::SYSCTL_OFS)) begin
                CFG_RDATA[sskdb_pkg::VOLT_BIT] <= volt_q;
                if (CFG_REQ.func == sskdb_pkg::FUNC_SOCK0) begin
                    CFG_RDATA[sskdb_pkg::PERR_FWD_BIT] <= perr_fwd_q;
                    CFG_RDATA[sskdb_pkg::DMA_EN_BIT] <= DMA_ENABLE;
                    CFG_RDATA[sskdb_pkg::HOLD_CLK_BIT] <= hold_clk_q;
                    CFG_RDATA[sskdb_pkg::WAKE_SEL_BIT] <= wake_sel_q;
                end
            end else if (CFG_REQ.rd && hit(CFG_REQ, sskdb_pkg::DEBOUNCE_OFS)) begin
                CFG_RDATA[sskdb_pkg::DEBOUNCE_W-1:0] <= debounce_q;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            SERR_REQ <= 1'b0;
        end else if (CE) begin
            SERR_REQ <= CARD_PARITY_ERR && perr_fwd_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            HOLD_CLOCKS_RUNNING <= 1'b0;
        end else if (CE) begin
            HOLD_CLOCKS_RUNNING <= hold_clk_q;
        end
    end

    // terminal mux; undriven when neither source selected
    always_ff @(posedge CLK) begin
        if (SRST) begin
            WAKE_RING_O <= 1'b0;
            WAKE_RING_OE <= 1'b0;
        end else if (CE) begin
            if (wake_sel_q) begin
                WAKE_RING_O <= PME_SIG;
                WAKE_RING_OE <= 1'b1;
            end else if (RING_IND_EN) begin
                WAKE_RING_O <= RING_IND_SIG;
                WAKE_RING_OE <= 1'b1;
            end else begin
                WAKE_RING_O <= 1'b0;
                WAKE_RING_OE <= 1'b0;
            end
        end
    end

    // pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge CLK) begin
        if (SRST) begin
            det_sync_q <= '1;
            det_raw_q <= 1'b1;
        end else if (CE) begin
            det_sync_q <= {det_sync_q[1:0], MEDIA_CARD_DETECT_N};
            if (det_sync_q[1] == det_sync_q[2]) begin
                det_raw_q <= det_sync_q[2];
            end
        end
    end

    // interval restarts whenever the raw level returns to the accepted one
    // raw is low-true, present high-true: equal values mean a change is pending
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pre_q <= '0;
            steps_q <= 8'h0;
            MEDIA_PRESENT <= 1'b0;
        end else if (CE) begin
            if (det_raw_q != MEDIA_PRESENT) begin
                pre_q <= '0;
                steps_q <= 8'h0;
            end else if (steps_q >= debounce_q) begin
                MEDIA_PRESENT <= !det_raw_q;
                pre_q <= '0;
                steps_q <= 8'h0;
            end else if (pre_q == PRE_LAST) begin
                pre_q <= '0;
                steps_q <= steps_q + 8'h1;
            end else begin
                pre_q <= pre_q + PRE_W'(1);
            end
        end
    end

    property p_serr_fwd;
        @(posedge CLK) disable iff (SRST)
        CE && CARD_PARITY_ERR && perr_fwd_q |=> SERR_REQ;
    endproperty
    a_serr_fwd: assert property (p_serr_fwd) else $error("parity not forwarded");

    property p_serr_quiet;
        @(posedge CLK) disable iff (SRST)
        CE && !perr_fwd_q |=> !SERR_REQ;
    endproperty
    a_serr_quiet: assert property (p_serr_quiet) else $error("parity forwarded off");

    property p_dma_write;
        @(posedge CLK) disable iff (SRST)
        CE && sys_wr |=> DMA_ENABLE == $past(CFG_REQ.wdata[sskdb_pkg::DMA_EN_BIT]);
    endproperty
    a_dma_write: assert property (p_dma_write) else $error("dma enable not written");

    property p_func1_global;
        @(posedge CLK) disable iff (SRST)
        CE && CFG_REQ.wr && CFG_REQ.func == sskdb_pkg::FUNC_SOCK1 |=>
            $stable(perr_fwd_q) && $stable(DMA_ENABLE) && $stable(wake_sel_q);
    endproperty
    a_func1_global: assert property (p_func1_global) else $error("func 1 wrote global");

    property p_hold_clk;
        @(posedge CLK) disable iff (SRST)
        CE |=> HOLD_CLOCKS_RUNNING == $past(hold_clk_q);
    endproperty
    a_hold_clk: assert property (p_hold_clk) else $error("hold clocks output wrong");

    property p_wake_route;
        @(posedge CLK) disable iff (SRST)
        CE && wake_sel_q |=> WAKE_RING_OE && WAKE_RING_O == $past(PME_SIG);
    endproperty
    a_wake_route: assert property (p_wake_route) else $error("wake not routed");

    property p_ring_route;
        @(posedge CLK) disable iff (SRST)
        CE && !wake_sel_q && RING_IND_EN |=> WAKE_RING_OE && WAKE_RING_O == $past(RING_IND_SIG);
    endproperty
    a_ring_route: assert property (p_ring_route) else $error("ring not routed");

    property p_term_off;
        @(posedge CLK) disable iff (SRST)
        CE && !wake_sel_q && !RING_IND_EN |=> !WAKE_RING_OE;
    endproperty
    a_term_off: assert property (p_term_off) else $error("terminal driven when off");

    property p_deb_reset;
        @(posedge CLK)
        SRST |=> debounce_q == sskdb_pkg::DEBOUNCE_RST && !perr_fwd_q && !wake_sel_q;
    endproperty
    a_deb_reset: assert property (p_deb_reset) else $error("reset value wrong");

    property p_no_early_accept;
        @(posedge CLK) disable iff (SRST)
        CE && steps_q < debounce_q |=> $stable(MEDIA_PRESENT);
    endproperty
    a_no_early_accept: assert property (p_no_early_accept) else $error("early accept");

    property p_ack_pulse;
        @(posedge CLK) disable iff (SRST)
        CE && (CFG_REQ.wr || CFG_REQ.rd) |=> CFG_ACK;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("access not acknowledged");

    property p_deb_write;
        @(posedge CLK) disable iff (SRST)
        CE && deb_wr |=> debounce_q == $past(CFG_REQ.wdata[sskdb_pkg::DEBOUNCE_W-1:0]);
    endproperty
    a_deb_write: assert property (p_deb_write) else $error("debounce not written");

    property p_deb_hold;
        @(posedge CLK) disable iff (SRST)
        CE && !deb_wr |=> $stable(debounce_q);
    endproperty
    a_deb_hold: assert property (p_deb_hold) else $error("debounce changed unasked");

    property p_deb_read;
        @(posedge CLK) disable iff (SRST)
        CE && CFG_REQ.rd && hit(CFG_REQ, sskdb_pkg::DEBOUNCE_OFS) |=>
            CFG_RDATA == 32'($past(debounce_q));
    endproperty
    a_deb_read: assert property (p_deb_read) else $error("debounce read wrong");

    property p_volt_ro;
        @(posedge CLK) disable iff (SRST)
        CE |=> volt_q == $past(LEGACY_5V_SEL);
    endproperty
    a_volt_ro: assert property (p_volt_ro) else $error("voltage bit not a mirror");

    property p_f1_read;
        @(posedge CLK) disable iff (SRST)
        CE && CFG_REQ.rd && CFG_REQ.func == sskdb_pkg::FUNC_SOCK1
            && CFG_REQ.addr == sskdb_pkg::SYSCTL_OFS |=>
            !CFG_RDATA[sskdb_pkg::PERR_FWD_BIT] && !CFG_RDATA[sskdb_pkg::DMA_EN_BIT]
            && !CFG_RDATA[sskdb_pkg::HOLD_CLK_BIT] && !CFG_RDATA[sskdb_pkg::WAKE_SEL_BIT];
    endproperty
    a_f1_read: assert property (p_f1_read) else $error("global bit read by func 1");

    property p_raw_glitch;
        @(posedge CLK) disable iff (SRST)
        CE && det_sync_q[1] != det_sync_q[2] |=> $stable(det_raw_q);
    endproperty
    a_raw_glitch: assert property (p_raw_glitch) else $error("pin glitch passed");

    property p_accept;
        @(posedge CLK) disable iff (SRST)
        CE && det_raw_q == MEDIA_PRESENT && steps_q >= debounce_q |=> $changed(MEDIA_PRESENT);
    endproperty
    a_accept: assert property (p_accept) else $error("settled detect not accepted");

    property p_step_count;
        @(posedge CLK) disable iff (SRST)
        CE && det_raw_q == MEDIA_PRESENT && steps_q < debounce_q && pre_q == PRE_LAST |=>
            steps_q == $past(steps_q) + 8'h1;
    endproperty
    a_step_count: assert property (p_step_count) else $error("step not counted");
endmodule : sskdb_top

/* File: verification/sskdb_sock_model.sv */
module sskdb_sock_model (
    input wire logic clk, // bench clock
    input wire logic insert, // card seated when high
    input wire logic term_o, // terminal level from device
    input wire logic term_oe, // terminal drive enable
    output logic detect_n, // media detect pin, low when present
    output wire logic term // resolved shared terminal
);
    timeunit 1ns;
    timeprecision 1ps;
    int bounce = 0;
    logic last = 1'b0;
    logic pin_q = 1'b1;
    // pulled up when nobody drives it
    assign term = term_oe ? term_o : 1'b1;
    assign detect_n = pin_q;
    // contacts chatter a few cycles on every insert or removal; moves on the
    // rising edge so it never races the bench's falling-edge stimulus
    always @(posedge clk) begin
        if (insert != last) begin
            last <= insert;
            bounce <= 5;
            pin_q <= ~pin_q;
        end else if (bounce > 1) begin
            bounce <= bounce - 1;
            pin_q <= ~pin_q;
        end else if (bounce == 1) begin
            bounce <= 0;
            pin_q <= ~last;
        end
    end
endmodule : sskdb_sock_model

/* File: verification/sskdb_top_bench.sv */
module sskdb_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 4;
    localparam logic [7:0] SYS = sskdb_pkg::SYSCTL_OFS;
    localparam logic [7:0] DEB = sskdb_pkg::DEBOUNCE_OFS;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    sskdb_pkg::sskdb_cfg_req_t req = '0;
    logic perr = 1'b0, v5 = 1'b0, ring_en = 1'b0, pme = 1'b0, ring = 1'b0, insert = 1'b0;
    logic [31:0] rdata;
    logic ack, serr, dma, hold, wr_o, wr_oe, present, det_n, term;
    int miscompares = 0;
    int n_checks = 0;
    always #4 clk = ~clk;
    sskdb_top #(.STEP_CYCLES(STEP)) dut_u (.CLK(clk), .SRST(srst), .CE(ce), .CFG_REQ(req),
        .CFG_RDATA(rdata), .CFG_ACK(ack), .CARD_PARITY_ERR(perr), .LEGACY_5V_SEL(v5),
        .RING_IND_EN(ring_en), .PME_SIG(pme), .RING_IND_SIG(ring), .MEDIA_CARD_DETECT_N(det_n),
        .SERR_REQ(serr), .DMA_ENABLE(dma), .HOLD_CLOCKS_RUNNING(hold), .WAKE_RING_O(wr_o),
        .WAKE_RING_OE(wr_oe), .MEDIA_PRESENT(present));
    sskdb_sock_model sock_u (.clk(clk), .insert(insert), .term_o(wr_o), .term_oe(wr_oe),
        .detect_n(det_n), .term(term));
    task automatic give_verdict();
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    // one access, then an idle cycle so the request never changes twice in a step
    task automatic acc(input logic w, input logic [2:0] f, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] e);
        req = '{w, ~w, f, a, 4'h1, d};
        @(negedge clk);
        chk("ack", 32'(ack), 32'h1);
        if (!w)
            chk("rdata", rdata, e);
        req = '0;
        @(negedge clk);
    endtask : acc
    task automatic settle(input logic e);
        for (int i = 0; i < 40 && present !== e; i++)
            @(negedge clk);
        chk("present", 32'(present), 32'(e));
    endtask : settle
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (10) @(negedge clk);
        srst = 1'b0;
        acc(0, 0, DEB, 0, 32'h19);
        acc(0, 1, DEB, 0, 32'h19);
        acc(0, 0, SYS, 0, 0);
        chk("outs", 32'({dma, hold, wr_oe, serr, present}), 0);
        for (int i = 0; i < 3; i++) begin
            acc(1, 3'(i % 2), DEB, 32'(8'hff >> (i * 4)), 0);
            acc(0, 3'(i % 2), DEB, 0, 32'(8'hff >> (i * 4)));
        end
        // request/grant routing sits outside this block; taken as set up before dma is enabled
        acc(1, 0, SYS, 32'h1b, 0);
        acc(0, 0, SYS, 0, 32'h1b);
        chk("dma hold", 32'({dma, hold}), 32'h3);
        v5 = 1'b1;
        @(negedge clk);
        acc(0, 1, SYS, 0, 32'h04);
        acc(1, 1, SYS, 0, 0);
        acc(0, 0, SYS, 0, 32'h1f);
        v5 = 1'b0;
        acc(1, 0, SYS, 32'h04, 0);
        acc(0, 0, SYS, 0, 0);
        chk("dma hold", 32'({dma, hold}), 0);
        acc(0, 0, 8'h88, 0, 0);
        acc(0, 2, DEB, 0, 0);
        for (int i = 0; i < 2; i++) begin
            acc(1, 0, SYS, 32'(i * 16), 0);
            perr = 1'b1;
            @(negedge clk);
            chk("serr", 32'(serr), 32'(i));
            perr = 1'b0;
            @(negedge clk);
            chk("serr off", 32'(serr), 0);
        end
        for (int i = 0; i < 8; i++) begin
            ring_en = i[1];
            pme = i[2];
            ring = ~i[2];
            acc(1, 0, SYS, 32'(i[0]), 0);
            chk("oe", 32'(wr_oe), 32'(i[0] | i[1]));
            chk("term", 32'(term), i[0] ? 32'(i[2]) : i[1] ? 32'(!i[2]) : 1);
        end
        acc(1, 0, DEB, 32'h3, 0);
        for (int i = 0; i < 2; i++) begin
            insert = ~insert;
            repeat (14) @(negedge clk);
            chk("early", 32'(present), 32'(i));
            settle(~i[0]);
        end
        acc(1, 0, SYS, 32'h1b, 0);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        acc(0, 0, DEB, 0, 32'h19);
        acc(0, 0, SYS, 0, 0);
        // a frozen block must neither answer nor take the write
        ce = 1'b0;
        req = '{1'b1, 1'b0, sskdb_pkg::FUNC_SOCK0, DEB, 4'h1, 32'h7};
        repeat (2) @(negedge clk);
        chk("frozen ack", 32'(ack), 0);
        req = '0;
        ce = 1'b1;
        @(negedge clk);
        // lane 0 disabled: acknowledged but not written
        req = '{1'b1, 1'b0, sskdb_pkg::FUNC_SOCK0, DEB, 4'he, 32'h7};
        @(negedge clk);
        chk("ack be", 32'(ack), 32'h1);
        req = '0;
        @(negedge clk);
        acc(0, 0, DEB, 0, 32'h19);
        give_verdict();
    end
endmodule : sskdb_top_bench
